// file: verilog/cmc_top.sv
// comparator control and output logic: two control registers, result
// latch, polarity, edge flag and pin routing
// assumes the analog core gives a raw decision (1 = negative below
// positive) and a one-cycle instruction strobe from the core clock
// limitation: the pin copy passes one output flop, so it trails the
// live decision by one clock but never waits for the strobe
//
// Operation
// R1 - The block holds a primary and a secondary control register.
// R2 - The secondary register has separate rising and falling edge enables.
// R3 - The secondary register selects the positive and negative sources.
// R4 - With comparator_on clear the analog core is disabled at least current.
// R5 - The result reads in cmp_result_bit and in cmp_result_mirror.
// R6 - The result can be routed to a pin whose pin_direction software clears.
// R7 - The internal result latches each instruction cycle; the pin is unlatched. With the sync bit set the code latches only when timer_sync_in is high.
// R8 - The result is 1 when negative is below positive, inverted by the bit.
// R9 - An enabled rising or falling edge of the latched result sets a flag.
`timescale 1ns/1ps
`include "cmc_params.svh"
module cmc_top (
   // clock, reset and freeze
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   // register writes from the core
   input wire logic pri_wr_in,
   input wire cmc_pkg::cmc_reg_t pri_wdata_in,
   input wire logic sec_wr_in,
   input wire cmc_pkg::cmc_reg_t sec_wdata_in,
   input wire logic flag_clr_in,
   // analog core and timing
   input wire logic analog_decision_in,
   input wire logic instr_cycle_in,
   input wire logic timer_sync_in,
   input wire logic pin_route_select_in,
   // register images
   output cmc_pkg::cmc_reg_t cmp_ctrl_primary_out,
   output cmc_pkg::cmc_reg_t cmp_ctrl_secondary_out,
   output logic cmp_result_mirror_out,
   output logic cmp_int_flag_out,
   // analog core controls
   output logic comparator_on_out,
   output logic hyst_en_out,
   output cmc_pkg::cmc_sel_t positive_input_out,
   output cmc_pkg::cmc_sel_t negative_input_out,
   // routed pin
   output logic pin_data_out
);
   import cmc_pkg::*;

   // control register group
   cmc_reg_t pri_r;
   cmc_reg_t pri_nxt;
   cmc_reg_t sec_r;
   cmc_reg_t sec_nxt;
   // result latch group
   logic result_r;
   logic result_nxt;
   // edge flag group
   logic flag_r;
   logic flag_nxt;
   // routed pin group
   logic pin_r;
   logic pin_nxt;
   // live terms shared by the groups
   logic polar;
   logic sample;
   logic armed;
   cmc_edge_t edge_ev;

   // apply the write mask so read-only bits keep hardware values
   function automatic cmc_reg_t merge(input cmc_reg_t old_v,
                                      input cmc_reg_t new_v,
                                      input cmc_reg_t mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction : merge

   // one select field of the secondary image; both selects share it
   // so the two fields cannot drift apart in width; each passes its own lsb
   function automatic cmc_sel_t sel_field(input cmc_reg_t img,
                                          input int lsb);
      sel_field = img[lsb +: `CMC_SEL_W];
   endfunction : sel_field

   // decision seen through the polarity bit; a core that is off reads 0
   function automatic logic apply_polarity(input logic on,
                                           input logic inv,
                                           input logic dec);
      apply_polarity = on & (dec ^ inv);
   endfunction : apply_polarity

   // an edge counts only when its own enable is set; the spare enum
   // code can only come from a fault, so it never raises the flag
   function automatic logic edge_armed(input cmc_edge_t ev,
                                       input cmc_reg_t img);
      edge_armed = 1'b0;
      unique case (ev)
         CMC_EDGE_NONE: edge_armed = 1'b0;
         CMC_EDGE_RISE: edge_armed = img[`CMC_SEC_RISE_BIT];
         CMC_EDGE_FALL: edge_armed = img[`CMC_SEC_FALL_BIT];
         default: edge_armed = 1'b0;
      endcase
   endfunction : edge_armed

   // live decision, sample strobe and edge arming
   // timer sync narrows the strobe rather than delaying the data
   always_comb begin
      polar = apply_polarity(pri_r[`CMC_PRI_ON_BIT],
                             pri_r[`CMC_PRI_INVERT_BIT],
                             analog_decision_in); // see R8
      sample = instr_cycle_in; // see R7
      if (pri_r[`CMC_PRI_SYNC_BIT]) begin
         sample = instr_cycle_in & timer_sync_in;
      end
      armed = edge_armed(edge_ev, sec_r); // see R2
   end

   // control registers next values
   always_comb begin
      pri_nxt = pri_r;
      sec_nxt = sec_r;
      if (pri_wr_in) begin
         pri_nxt = merge(pri_r, pri_wdata_in, `CMC_PRI_WMASK); // see R1
      end
      if (sec_wr_in) begin
         sec_nxt = merge(sec_r, sec_wdata_in, `CMC_SEC_WMASK); // see R3
      end
      // status bit tracks the latch, never the write data
      pri_nxt[`CMC_PRI_RESULT_BIT] = result_nxt; // see R5
   end

   // control registers; frozen while the clock enable is low
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pri_r <= `CMC_PRI_RESET;
         sec_r <= `CMC_SEC_RESET;
      end else if (clk_en_in) begin
         pri_r <= pri_nxt;
         sec_r <= sec_nxt;
      end
   end

   // result latch next value: only the strobe moves it, so two reads
   // inside one instruction cycle always agree
   always_comb begin
      result_nxt = result_r;
      if (sample) begin
         result_nxt = polar; // see R7
      end
   end

   // result latch register; the edge detector keeps its own copy so
   // the flag path needs no tap on this flop
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         result_r <= 1'b0;
      end else if (clk_en_in) begin
         result_r <= result_nxt;
      end
   end

   // edge flag next value: set beats clear so an edge landing on the
   // clearing write is not lost
   always_comb begin
      flag_nxt = flag_r;
      if (flag_clr_in) begin
         flag_nxt = 1'b0;
      end
      if (armed) begin
         flag_nxt = 1'b1; // see R9
      end
   end

   // edge flag register
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flag_r <= 1'b0;
      end else if (clk_en_in) begin
         flag_r <= flag_nxt;
      end
   end

   // pin follows the unlatched polar value; the single output flop
   // keeps the pin glitch free at the cost of one clock of delay
   always_comb begin
      pin_nxt = 1'b0;
      if (pin_route_select_in) begin
         pin_nxt = polar; // see R6
      end
   end

   // routed pin register
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_r <= 1'b0;
      end else if (clk_en_in) begin
         pin_r <= pin_nxt;
      end
   end

   // edge detection on the latched result
   cmc_edge_det u_edge (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .clk_en_in(clk_en_in),
      .sample_in(sample),
      .level_in(polar),
      .edge_out(edge_ev)
   );

   // outputs straight from registers
   assign cmp_ctrl_primary_out = pri_r;
   assign cmp_ctrl_secondary_out = sec_r;
   assign cmp_result_mirror_out = result_r; // see R5
   assign cmp_int_flag_out = flag_r;
   assign comparator_on_out = pri_r[`CMC_PRI_ON_BIT]; // see R4
   assign hyst_en_out = pri_r[`CMC_PRI_HYST_BIT];
   assign positive_input_out =
      sel_field(sec_r, `CMC_SEC_PSEL_LSB); // see R3
   assign negative_input_out =
      sel_field(sec_r, `CMC_SEC_NSEL_LSB); // see R3
   assign pin_data_out = pin_r;
endmodule : cmc_top

// file: verilog/cmc_params.svh
// constants for the comparator control logic: field positions and resets
// assumes an 8-bit register image for each control register
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH

// primary control register field positions
`define CMC_PRI_ON_BIT 7
`define CMC_PRI_RESULT_BIT 6
`define CMC_PRI_INVERT_BIT 4
`define CMC_PRI_HYST_BIT 1
`define CMC_PRI_SYNC_BIT 0
`define CMC_PRI_WMASK 8'h93
`define CMC_PRI_RESET 8'h00

// secondary control register field positions
`define CMC_SEC_RISE_BIT 7
`define CMC_SEC_FALL_BIT 6
`define CMC_SEC_PSEL_LSB 3
`define CMC_SEC_NSEL_LSB 0
`define CMC_SEC_WMASK 8'hff
`define CMC_SEC_RESET 8'h00

// selection field width
`define CMC_SEL_W 3

`endif

// file: verilog/cmc_pkg.sv
// types shared by the comparator control logic
// assumes cmc_params.svh is in the include path
package cmc_pkg;
   typedef logic [7:0] cmc_reg_t;
   typedef logic [2:0] cmc_sel_t;
   typedef enum logic [1:0] {
      CMC_EDGE_NONE,
      CMC_EDGE_RISE,
      CMC_EDGE_FALL
   } cmc_edge_t;
endpackage : cmc_pkg

// file: verilog/cmc_edge_det.sv
// edge detector on the latched comparator result
// assumes the sample strobe is synchronous to sys_clk_in
`timescale 1ns/1ps
module cmc_edge_det (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   // sampled level
   input wire logic sample_in,
   input wire logic level_in,
   // edge report
   output cmc_pkg::cmc_edge_t edge_out
);
   import cmc_pkg::*;

   logic prev_r;
   logic prev_nxt;
   cmc_edge_t edge_r;
   cmc_edge_t edge_nxt;

   // compare each new sample with the previous one
   always_comb begin
      prev_nxt = prev_r;
      edge_nxt = CMC_EDGE_NONE;
      if (sample_in) begin
         prev_nxt = level_in;
         if (level_in && !prev_r) begin
            edge_nxt = CMC_EDGE_RISE;
         end else if (!level_in && prev_r) begin
            edge_nxt = CMC_EDGE_FALL;
         end
      end
   end

   // registers; frozen while the clock enable is low
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prev_r <= 1'b0;
         edge_r <= CMC_EDGE_NONE;
      end else if (clk_en_in) begin
         prev_r <= prev_nxt;
         edge_r <= edge_nxt;
      end
   end

   assign edge_out = edge_r;
endmodule : cmc_edge_det

// file: bench/cmc_core_model.sv
// analog core stand-in: select codes act as input voltages
// assumes enable and selects come straight from cmc_top
`timescale 1ns/1ps
module cmc_core_model (
   input wire logic on_in,
   input wire cmc_pkg::cmc_sel_t pos_sel_in,
   input wire cmc_pkg::cmc_sel_t neg_sel_in,
   output logic decision_out
);
   import cmc_pkg::*;
   // a disabled core reports low rather than a stale level
   assign decision_out = on_in && (neg_sel_in < pos_sel_in);
endmodule : cmc_core_model

// file: bench/cmc_properties.sv
// checker for cmc_top, bound from the bench top
// assumes one clock and the port names of cmc_top
`timescale 1ns/1ps
module cmc_properties (
   // watched ports
   input wire logic sys_clk_in, arst_n_in, clk_en_in, pri_wr_in,
   input wire logic sec_wr_in, instr_cycle_in, analog_decision_in,
   input wire logic pin_route_select_in, comparator_on_out, hyst_en_out,
   input wire logic cmp_result_mirror_out, cmp_int_flag_out, pin_data_out,
   input wire cmc_pkg::cmc_reg_t pri_wdata_in, sec_wdata_in,
   input wire cmc_pkg::cmc_reg_t cmp_ctrl_primary_out,
   input wire cmc_pkg::cmc_reg_t cmp_ctrl_secondary_out
);
   import cmc_pkg::*;
   wire logic m = cmp_result_mirror_out;
   wire logic inv = cmp_ctrl_primary_out[4];
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_rise; $rose(m) && cmp_ctrl_secondary_out[7]; endsequence
   sequence s_fall; $fell(m) && cmp_ctrl_secondary_out[6]; endsequence
   property p_mir; m == cmp_ctrl_primary_out[6]; endproperty
   a_mir: assert property (p_mir) else $error("mirror");
   property p_pri; pri_wr_in && clk_en_in |=>
      (cmp_ctrl_primary_out & 8'hbf) == ($past(pri_wdata_in) & 8'h93);
   endproperty
   a_pri: assert property (p_pri) else $error("primary");
   property p_sec; sec_wr_in && clk_en_in |=>
      cmp_ctrl_secondary_out == $past(sec_wdata_in); endproperty
   a_sec: assert property (p_sec) else $error("secondary");
   property p_on; comparator_on_out == cmp_ctrl_primary_out[7]; endproperty
   a_on: assert property (p_on) else $error("enable");
   property p_hyst; hyst_en_out == cmp_ctrl_primary_out[1]; endproperty
   a_hyst: assert property (p_hyst) else $error("hysteresis");
   // pri writes excluded, though switching off clears the result only at the next strobe
   property p_hold; !instr_cycle_in && !pri_wr_in |=> $stable(m); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_smp; instr_cycle_in && clk_en_in && !pri_wr_in &&
      comparator_on_out && !cmp_ctrl_primary_out[0] |=>
      m == ($past(analog_decision_in) ^ inv); endproperty
   a_smp: assert property (p_smp) else $error("sample");
   property p_edge; s_rise or s_fall |=> cmp_int_flag_out; endproperty
   a_edge: assert property (p_edge) else $error("edge");
   property p_pin; pin_route_select_in && comparator_on_out && !pri_wr_in
      |=> pin_data_out == ($past(analog_decision_in) ^ inv); endproperty
   a_pin: assert property (p_pin) else $error("pin");
endmodule : cmc_properties

// file: bench/tb.sv
// self-checking bench: cmc_top against the analog core stand-in
// assumes design, model and checker are compiled before it
`timescale 1ns/1ps
module tb;
   import cmc_pkg::*;
   logic sys_clk_in = 0, arst_n_in = 0, clk_en_in = 1, pri_wr_in = 0;
   logic sec_wr_in = 0, flag_clr_in = 0, instr_cycle_in = 0;
   logic timer_sync_in = 0, pin_route_select_in = 0, analog_decision_in;
   logic cmp_result_mirror_out, cmp_int_flag_out, comparator_on_out;
   logic hyst_en_out, pin_data_out;
   logic [1:0] cyc = 0;
   cmc_reg_t pri_wdata_in = 8'h00, sec_wdata_in = 8'h00;
   cmc_reg_t cmp_ctrl_primary_out, cmp_ctrl_secondary_out;
   cmc_sel_t positive_input_out, negative_input_out;
   int fails = 0, n_tests = 0;
   always #10 sys_clk_in = ~sys_clk_in;
   // one-in-four instruction strobe
   always @(negedge sys_clk_in) begin
      cyc <= cyc + 2'h1;
      instr_cycle_in <= (cyc == 2'h3);
   end
   cmc_core_model core_u (.on_in(comparator_on_out),
      .pos_sel_in(positive_input_out), .neg_sel_in(negative_input_out),
      .decision_out(analog_decision_in));
   cmc_top dut_u (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .clk_en_in(clk_en_in),
      .pri_wr_in(pri_wr_in),
      .pri_wdata_in(pri_wdata_in),
      .sec_wr_in(sec_wr_in),
      .sec_wdata_in(sec_wdata_in),
      .flag_clr_in(flag_clr_in),
      .analog_decision_in(analog_decision_in),
      .instr_cycle_in(instr_cycle_in),
      .timer_sync_in(timer_sync_in),
      .pin_route_select_in(pin_route_select_in),
      .cmp_ctrl_primary_out(cmp_ctrl_primary_out),
      .cmp_ctrl_secondary_out(cmp_ctrl_secondary_out),
      .cmp_result_mirror_out(cmp_result_mirror_out),
      .cmp_int_flag_out(cmp_int_flag_out),
      .comparator_on_out(comparator_on_out),
      .hyst_en_out(hyst_en_out),
      .positive_input_out(positive_input_out),
      .negative_input_out(negative_input_out),
      .pin_data_out(pin_data_out)
   );
   task final_report;
      $display("checks %0d bad %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task chk(input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // flag cleared with each write so every step starts clean
   task wr(input logic p, input cmc_reg_t d);
      @(negedge sys_clk_in);
      {pri_wr_in, sec_wr_in, flag_clr_in} <= {p, !p, 1'b1};
      {pri_wdata_in, sec_wdata_in} <= {d, d};
      @(negedge sys_clk_in);
      {pri_wr_in, sec_wr_in, flag_clr_in} <= 3'h0;
   endtask : wr
   // write, bounded wait for the new result, then judge the edge flag
   task step(input logic p, input cmc_reg_t d, input logic r, f);
      wr(p, d);
      for (int i = 0; i < 9 && cmp_result_mirror_out !== r; i++)
         @(negedge sys_clk_in);
      chk(16'(cmp_result_mirror_out), 16'(r));
      chk(16'(cmp_ctrl_primary_out[6]), 16'(r));
      if (cmp_result_mirror_out !== r) final_report();
      @(negedge sys_clk_in);
      chk(16'(cmp_int_flag_out), 16'(f));
   endtask : step
   initial begin
      repeat (20) @(negedge sys_clk_in);
      arst_n_in <= 1;
      chk({cmp_ctrl_primary_out, cmp_ctrl_secondary_out}, 16'h0000);
      pin_route_select_in <= 1;
      wr(1, 8'hff);
      chk(16'(cmp_ctrl_primary_out), 16'h0093);
      chk(16'(hyst_en_out), 16'h0001);
      wr(0, 8'hc5);
      chk({10'h000, positive_input_out, negative_input_out}, 16'h0005);
      repeat (8) @(negedge sys_clk_in);
      chk(16'(cmp_result_mirror_out), 16'h0000);
      timer_sync_in <= 1;
      step(0, 8'hc5, 1, 1);
      step(0, 8'h68, 0, 1);
      step(1, 8'h80, 1, 0);
      step(0, 8'h85, 0, 0);
      step(0, 8'ha8, 1, 1);
      chk(16'(pin_data_out), 16'h0001);
      // frozen: a write and a clear must both be ignored
      clk_en_in <= 0;
      wr(1, 8'h00);
      chk(16'(cmp_ctrl_primary_out), 16'h00c0);
      chk(16'(cmp_int_flag_out), 16'h0001);
      clk_en_in <= 1;
      step(1, 8'h00, 0, 0);
      chk(16'(comparator_on_out), 16'h0000);
      final_report();
   end
endmodule : tb
bind cmc_top cmc_properties chk_u (
   .sys_clk_in(sys_clk_in),
   .arst_n_in(arst_n_in),
   .clk_en_in(clk_en_in),
   .pri_wr_in(pri_wr_in),
   .sec_wr_in(sec_wr_in),
   .instr_cycle_in(instr_cycle_in),
   .analog_decision_in(analog_decision_in),
   .pin_route_select_in(pin_route_select_in),
   .comparator_on_out(comparator_on_out),
   .hyst_en_out(hyst_en_out),
   .cmp_result_mirror_out(cmp_result_mirror_out),
   .cmp_int_flag_out(cmp_int_flag_out),
   .pin_data_out(pin_data_out),
   .pri_wdata_in(pri_wdata_in),
   .sec_wdata_in(sec_wdata_in),
   .cmp_ctrl_primary_out(cmp_ctrl_primary_out),
   .cmp_ctrl_secondary_out(cmp_ctrl_secondary_out)
);
